// File: hdl/otg_status_token.sv
// otg status, frame number high and token issue registers
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - status bit 7 shows cable identity pin: 1 none or B, 0 A cable
// - status bit 5 set only after se0 and j state unchanged for 1 ms
// - status bit 3 shows vbus above session valid threshold
// - status bit 2 shows b role vbus below session valid
// - status bit 0 shows a role vbus valid
// - status flags read only, reset 0; other bits read zero
// - upper three frame number bits captured at bits 2-0 on each sof
// - frame high bits 31-3 read zero; field resets to 0
// - token type field bits 7-4: 1101 setup, 1001 in, 0001 out
// - token bits 31-8 read zero; fields reset to 0
module otg_status_token
	import otg_stat_pkg::*;
(
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_RST,
	// register port
	input wire otg_stat_pkg::bus_req_s I_BUS,
	output logic [31:0] O_RDATA,
	// line and vbus indications
	input wire otg_stat_pkg::line_in_s I_LINE,
	// received sof with its frame number
	input wire logic I_SOF,
	input wire logic [10:0] I_FRAME_NUM,
	// token issued to the transaction engine
	output logic O_TOKEN_GO,
	output logic [3:0] O_TOKEN_PID,
	output logic [3:0] O_TOKEN_EP,
	// interrupt
	output logic O_IRQ
);
	import otg_stat_pkg::*;

	typedef struct packed {
		logic [7:0] status;
		logic [2:0] frame_upper;
		logic [3:0] token_pid;
		logic [3:0] token_ep;
		logic token_go;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_en;
		logic irq;
		logic [31:0] rdata;
	} state_s;

	state_s st_ff;
	state_s nxt_st;
	logic line_stable;

	function automatic logic [31:0] zext8(input logic [7:0] v);
		zext8 = {24'h00_0000, v};
	endfunction : zext8

	line_stable_timer u_stable (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_se0(I_LINE.se0),
		.i_j_state(I_LINE.j_state),
		.o_stable(line_stable)
	);

	always_comb begin
		logic [IRQ_W-1:0] ev;
		ev = '0;
		nxt_st = st_ff;
		nxt_st.token_go = 1'b0;
		nxt_st.status = 8'h00;
		nxt_st.status[BIT_ID] = I_LINE.id_pin;
		nxt_st.status[BIT_LSTABLE] = line_stable;
		nxt_st.status[BIT_SESSION] = I_LINE.session_valid;
		nxt_st.status[BIT_BSEND] = I_LINE.b_session_end;
		nxt_st.status[BIT_AVBUS] = I_LINE.a_vbus_valid;
		if (I_SOF) begin
			nxt_st.frame_upper = I_FRAME_NUM[10:8];
		end
		if (I_BUS.wr && I_BUS.addr == ADDR_TOKEN_ISSUE) begin
			nxt_st.token_pid = I_BUS.wdata[TOK_PID_LSB +: 4];
			nxt_st.token_ep = I_BUS.wdata[3:0];
			nxt_st.token_go = 1'b1;
		end
		if (I_BUS.wr && I_BUS.addr == ADDR_IRQ_ENABLE) begin
			nxt_st.irq_en = I_BUS.wdata[IRQ_W-1:0];
		end
		ev[IRQ_ID_CHG] = nxt_st.status[BIT_ID] != st_ff.status[BIT_ID];
		ev[IRQ_SES_CHG] = nxt_st.status[BIT_SESSION] != st_ff.status[BIT_SESSION];
		ev[IRQ_SOF] = I_SOF;
		ev[IRQ_TOKEN] = nxt_st.token_go;
		if (I_BUS.wr && I_BUS.addr == ADDR_IRQ_CLEAR) begin
			nxt_st.irq_stat = st_ff.irq_stat & ~I_BUS.wdata[IRQ_W-1:0];
		end
		nxt_st.irq_stat = nxt_st.irq_stat | ev;
		nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_en);
		nxt_st.rdata = REG_ZERO;
		if (I_BUS.rd) begin
			unique case (I_BUS.addr)
				ADDR_OTG_STATUS: nxt_st.rdata = zext8(st_ff.status);
				ADDR_FRAME_HIGH: nxt_st.rdata = zext8({5'h00, st_ff.frame_upper});
				ADDR_TOKEN_ISSUE: nxt_st.rdata = zext8({st_ff.token_pid, st_ff.token_ep});
				ADDR_IRQ_STATUS: nxt_st.rdata = zext8({4'h0, st_ff.irq_stat});
				ADDR_IRQ_ENABLE: nxt_st.rdata = zext8({4'h0, st_ff.irq_en});
				default: nxt_st.rdata = REG_ZERO;
			endcase
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign O_RDATA = st_ff.rdata;
	assign O_TOKEN_GO = st_ff.token_go;
	assign O_TOKEN_PID = st_ff.token_pid;
	assign O_TOKEN_EP = st_ff.token_ep;
	assign O_IRQ = st_ff.irq;

	a_id_follows_pin: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_BUS.rd && I_BUS.addr == ADDR_OTG_STATUS ##1 !$past(I_RST, 2)
		|-> O_RDATA[BIT_ID] == $past(I_LINE.id_pin, 2))
		else $error("id bit does not follow the pin");
	a_stable_read: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_BUS.rd && I_BUS.addr == ADDR_OTG_STATUS && !$past(I_RST)
		|=> O_RDATA[BIT_LSTABLE] == $past(line_stable, 2))
		else $error("stable flag read differs from the timer");
	a_session_bit: assert property (@(posedge I_CLK) disable iff (I_RST)
		##2 st_ff.status[BIT_SESSION] == $past(I_LINE.session_valid, 1))
		else $error("session valid bit wrong");
	a_bsend_bit: assert property (@(posedge I_CLK) disable iff (I_RST)
		##2 st_ff.status[BIT_BSEND] == $past(I_LINE.b_session_end, 1))
		else $error("b session end bit wrong");
	a_avbus_bit: assert property (@(posedge I_CLK) disable iff (I_RST)
		##2 st_ff.status[BIT_AVBUS] == $past(I_LINE.a_vbus_valid, 1))
		else $error("a vbus valid bit wrong");
	a_status_zeros: assert property (@(posedge I_CLK) disable iff (I_RST)
		(O_RDATA[31:8] == 24'h00_0000) && !O_RDATA[6] && !O_RDATA[4] && !O_RDATA[1]
		|| $past(I_BUS.addr) != ADDR_OTG_STATUS)
		else $error("unimplemented status bit set");
	a_sof_capture: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_SOF |=> st_ff.frame_upper == $past(I_FRAME_NUM[10:8]))
		else $error("frame upper not captured on sof");
	a_frame_zeros: assert property (@(posedge I_CLK) disable iff (I_RST)
		$past(I_BUS.rd) && $past(I_BUS.addr) == ADDR_FRAME_HIGH |-> O_RDATA[31:3] == '0)
		else $error("frame high upper bits set");
	a_token_write: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_BUS.wr && I_BUS.addr == ADDR_TOKEN_ISSUE
		|=> O_TOKEN_GO && O_TOKEN_PID == $past(I_BUS.wdata[7:4]))
		else $error("token write not taken");
	a_token_zeros: assert property (@(posedge I_CLK) disable iff (I_RST)
		$past(I_BUS.rd) && $past(I_BUS.addr) == ADDR_TOKEN_ISSUE |-> O_RDATA[31:8] == '0)
		else $error("token upper bits set");
	a_irq_level: assert property (@(posedge I_CLK) disable iff (I_RST)
		O_IRQ == |(st_ff.irq_stat & st_ff.irq_en))
		else $error("irq level wrong");
	a_token_ep_write: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_BUS.wr && I_BUS.addr == ADDR_TOKEN_ISSUE
		|=> O_TOKEN_EP == $past(I_BUS.wdata[3:0]))
		else $error("token endpoint not taken");
	a_token_hold: assert property (@(posedge I_CLK) disable iff (I_RST)
		!(I_BUS.wr && I_BUS.addr == ADDR_TOKEN_ISSUE)
		|=> $stable(O_TOKEN_PID) && $stable(O_TOKEN_EP))
		else $error("token fields changed without a write");
	a_token_read: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_BUS.rd && I_BUS.addr == ADDR_TOKEN_ISSUE
		|=> O_RDATA[7:0] == $past({O_TOKEN_PID, O_TOKEN_EP}))
		else $error("token read differs from the stored fields");
	a_go_only_write: assert property (@(posedge I_CLK) disable iff (I_RST)
		O_TOKEN_GO |-> $past(I_BUS.wr && I_BUS.addr == ADDR_TOKEN_ISSUE))
		else $error("token pulse without a token write");
	a_frame_read: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_BUS.rd && I_BUS.addr == ADDR_FRAME_HIGH
		|=> O_RDATA[2:0] == $past(st_ff.frame_upper))
		else $error("frame upper read differs from the captured field");
	a_frame_hold: assert property (@(posedge I_CLK) disable iff (I_RST)
		!I_SOF |=> $stable(st_ff.frame_upper))
		else $error("frame upper changed without sof");
	a_rdata_idle: assert property (@(posedge I_CLK) disable iff (I_RST)
		!I_BUS.rd |=> O_RDATA == REG_ZERO)
		else $error("read data not zero outside a read");
	a_sof_flag_set: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_SOF |=> st_ff.irq_stat[IRQ_SOF])
		else $error("sof did not set its status flag");
	a_token_flag_set: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_BUS.wr && I_BUS.addr == ADDR_TOKEN_ISSUE |=> st_ff.irq_stat[IRQ_TOKEN])
		else $error("token write did not set its status flag");
	a_token_flag_clr: assert property (@(posedge I_CLK) disable iff (I_RST)
		I_BUS.wr && I_BUS.addr == ADDR_IRQ_CLEAR && I_BUS.wdata[IRQ_TOKEN]
		|=> !st_ff.irq_stat[IRQ_TOKEN])
		else $error("token status flag survived its clear");
	a_id_flag_set: assert property (@(posedge I_CLK) disable iff (I_RST)
		!$past(I_RST) && st_ff.status[BIT_ID] != $past(st_ff.status[BIT_ID])
		|-> st_ff.irq_stat[IRQ_ID_CHG])
		else $error("id change did not set its status flag");
	a_ses_flag_set: assert property (@(posedge I_CLK) disable iff (I_RST)
		!$past(I_RST) && st_ff.status[BIT_SESSION] != $past(st_ff.status[BIT_SESSION])
		|-> st_ff.irq_stat[IRQ_SES_CHG])
		else $error("session change did not set its status flag");
	a_reset_clean: assert property (@(posedge I_CLK)
		$fell(I_RST) |-> O_RDATA == REG_ZERO && !O_TOKEN_GO && !O_IRQ
		&& O_TOKEN_PID == 4'h0 && O_TOKEN_EP == 4'h0
		&& st_ff.status == 8'h00 && st_ff.frame_upper == 3'h0)
		else $error("state not cleared by reset");

	c_sof_seen: cover property (@(posedge I_CLK) I_SOF);
	c_token_setup: cover property (@(posedge I_CLK) O_TOKEN_GO && O_TOKEN_PID == PID_SETUP);
	c_line_stable: cover property (@(posedge I_CLK) $rose(line_stable));
	c_irq_raised: cover property (@(posedge I_CLK) $rose(O_IRQ));
endmodule : otg_status_token
`default_nettype wire

// File: hdl/otg_stat_pkg.sv
// constants, types and register map of the otg status and token block
package otg_stat_pkg;
	localparam int unsigned CLK_HZ = 125000000;
	localparam int unsigned STABLE_TIME_US = 1000;
	localparam int unsigned STABLE_CYCLES = (CLK_HZ / 1000000) * STABLE_TIME_US;
	localparam int unsigned STABLE_CNT_W = 17;

	localparam logic [7:0] ADDR_OTG_STATUS = 8'h00;
	localparam logic [7:0] ADDR_FRAME_HIGH = 8'h04;
	localparam logic [7:0] ADDR_TOKEN_ISSUE = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h14;

	localparam int unsigned BIT_ID = 7;
	localparam int unsigned BIT_LSTABLE = 5;
	localparam int unsigned BIT_SESSION = 3;
	localparam int unsigned BIT_BSEND = 2;
	localparam int unsigned BIT_AVBUS = 0;

	localparam int unsigned TOK_PID_LSB = 4;
	localparam logic [3:0] PID_SETUP = 4'hD;
	localparam logic [3:0] PID_IN = 4'h9;
	localparam logic [3:0] PID_OUT = 4'h1;

	localparam int unsigned IRQ_W = 4;
	localparam int unsigned IRQ_ID_CHG = 0;
	localparam int unsigned IRQ_SES_CHG = 1;
	localparam int unsigned IRQ_SOF = 2;
	localparam int unsigned IRQ_TOKEN = 3;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
	localparam logic [31:0] REG_ZERO = 32'h0000_0000;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} bus_req_s;

	typedef struct packed {
		logic id_pin;
		logic se0;
		logic j_state;
		logic session_valid;
		logic b_session_end;
		logic a_vbus_valid;
	} line_in_s;
endpackage : otg_stat_pkg

// File: hdl/line_stable_timer.sv
// watches se0 and j state and flags them stable after a full interval
`timescale 1ns/1ns
`default_nettype none
module line_stable_timer
	import otg_stat_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// line indications
	input wire logic i_se0,
	input wire logic i_j_state,
	// result
	output logic o_stable
);
	typedef struct packed {
		logic [1:0] last;
		logic [STABLE_CNT_W-1:0] cnt;
		logic stable;
	} tmr_s;

	localparam logic [STABLE_CNT_W-1:0] CNT_END = STABLE_CNT_W'(STABLE_CYCLES - 1);

	tmr_s st_ff;
	tmr_s nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.last = {i_se0, i_j_state};
		if (nxt_st.last != st_ff.last) begin
			nxt_st.cnt = '0;
			nxt_st.stable = 1'b0;
		end else if (st_ff.cnt == CNT_END) begin
			nxt_st.stable = 1'b1;
		end else begin
			nxt_st.cnt = st_ff.cnt + 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_stable = st_ff.stable;

	a_change_clears: assert property (@(posedge i_clk) disable iff (i_rst)
		({i_se0, i_j_state} != st_ff.last) |=> !o_stable)
		else $error("stable flag survived a line change");
endmodule : line_stable_timer
`default_nettype wire

// File: tb/usb_far_end.sv
// far side model: line levels and sof tokens with a running frame number
`timescale 1ns/1ns
`default_nettype none
module usb_far_end
	import otg_stat_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// commands from the bench
	input wire otg_stat_pkg::line_in_s i_line,
	input wire logic i_sof_req,
	input wire logic i_load,
	input wire logic [10:0] i_frame,
	// towards the block
	output var otg_stat_pkg::line_in_s o_line,
	output logic o_sof,
	output logic [10:0] o_frame_num
);
	logic [10:0] frame_ff;
	assign o_frame_num = frame_ff;
	always_ff @(posedge i_clk) begin
		o_line <= i_line;
		if (i_rst) begin
			frame_ff <= 11'h000;
			o_sof <= 1'b0;
		end else begin
			o_sof <= i_sof_req;
			// frame number moves on after each sof, as a real host does
			if (i_load) begin
				frame_ff <= i_frame;
			end else if (o_sof) begin
				frame_ff <= frame_ff + 11'h001;
			end
		end
	end
endmodule : usb_far_end
`default_nettype wire

// File: tb/otg_status_token_tb.sv
// self-checking bench for the otg status and token block
`timescale 1ns/1ns
`default_nettype none
module otg_status_token_tb;
	import otg_stat_pkg::*;
	logic I_CLK = 1'b0;
	logic I_RST = 1'b1;
	bus_req_s bus = '0;
	line_in_s line = '0;
	line_in_s line_w;
	logic [31:0] rdata;
	logic go, irq, sof, sof_req = 1'b0, load = 1'b0;
	logic [3:0] pid, ep;
	logic [10:0] fnum, fset = 11'h000;
	logic [10:0] ft [3] = '{11'h5A3, 11'h7FF, 11'h0FF};
	logic [3:0] pt [3] = '{PID_SETUP, PID_IN, PID_OUT};
	logic [3:0] et [3] = '{4'h0, 4'h7, 4'hF};
	int miscompares = 0;
	int checks_done = 0;
	always #4 I_CLK = ~I_CLK;
	otg_status_token DUT (.I_CLK(I_CLK), .I_RST(I_RST), .I_BUS(bus), .O_RDATA(rdata),
		.I_LINE(line_w), .I_SOF(sof), .I_FRAME_NUM(fnum), .O_TOKEN_GO(go),
		.O_TOKEN_PID(pid), .O_TOKEN_EP(ep), .O_IRQ(irq));
	usb_far_end far (.i_clk(I_CLK), .i_rst(I_RST), .i_line(line), .i_sof_req(sof_req),
		.i_load(load), .i_frame(fset), .o_line(line_w), .o_sof(sof), .o_frame_num(fnum));
	function automatic logic [31:0] st(input line_in_s l, input logic s);
		return {24'h00_0000, l.id_pin, 1'b0, s, 1'b0, l.session_valid, l.b_session_end,
			1'b0, l.a_vbus_valid};
	endfunction : st
	task conclude;
		if (miscompares == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : conclude
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge I_CLK);
		bus <= '{a, v, 1'b1, 1'b0};
		@(posedge I_CLK);
		bus.wr <= 1'b0;
		#1;
	endtask : wr
	task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		@(posedge I_CLK);
		bus <= '{a, REG_ZERO, 1'b0, 1'b1};
		@(posedge I_CLK);
		bus.rd <= 1'b0;
		#1 chk(n, e, rdata);
	endtask : rchk
	task sof_at(input logic [10:0] f);
		@(posedge I_CLK);
		fset <= f;
		load <= 1'b1;
		@(posedge I_CLK);
		load <= 1'b0;
		sof_req <= 1'b1;
		@(posedge I_CLK);
		sof_req <= 1'b0;
		repeat (2) @(posedge I_CLK);
	endtask : sof_at
	initial begin
		#1_200_000;
		miscompares++;
		conclude();
	end
	initial begin
		repeat (16) @(posedge I_CLK);
		I_RST <= 1'b0;
		line.id_pin <= 1'b1;
		repeat (3) @(posedge I_CLK);
		rchk("status", ADDR_OTG_STATUS, st(line, 1'b0));
		rchk("frame_high", ADDR_FRAME_HIGH, REG_ZERO);
		rchk("token", ADDR_TOKEN_ISSUE, REG_ZERO);
		wr(ADDR_OTG_STATUS, 32'hFFFF_FFFF);
		rchk("status", ADDR_OTG_STATUS, st(line, 1'b0));
		for (int i = 0; i < 4; i++) begin
			line.id_pin <= ~i[0];
			line.session_valid <= i[0];
			line.b_session_end <= i[1];
			line.a_vbus_valid <= i[0] ^ i[1];
			repeat (3) @(posedge I_CLK);
			rchk("status", ADDR_OTG_STATUS, st(line, 1'b0));
		end
		for (int i = 0; i < 3; i++) begin
			sof_at(ft[i]);
			rchk("frame_high", ADDR_FRAME_HIGH, {29'h0000_0000, ft[i][10:8]});
		end
		// id change after reset, session changes in the loop and the sofs
		rchk("irq_status", ADDR_IRQ_STATUS, 32'h0000_0007);
		wr(ADDR_IRQ_CLEAR, 32'h0000_000F);
		rchk("irq_status", ADDR_IRQ_STATUS, REG_ZERO);
		wr(ADDR_IRQ_ENABLE, 32'h0000_0008);
		chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
		rchk("irq_enable", ADDR_IRQ_ENABLE, 32'h0000_0008);
		for (int i = 0; i < 3; i++) begin
			// upper bits written as ones must not stick; codes and endpoints from the tables
			wr(ADDR_TOKEN_ISSUE, {24'hFF_FFFF, pt[i], et[i]});
			chk("go", 32'h0000_0001, {31'h0000_0000, go});
			chk("pid_ep", {24'h00_0000, pt[i], et[i]}, {24'h00_0000, pid, ep});
			rchk("token", ADDR_TOKEN_ISSUE, {24'h00_0000, pt[i], et[i]});
			chk("go", 32'h0000_0000, {31'h0000_0000, go});
		end
		chk("irq", 32'h0000_0001, {31'h0000_0000, irq});
		rchk("irq_status", ADDR_IRQ_STATUS, 32'h0000_0008);
		wr(ADDR_IRQ_CLEAR, 32'h0000_0008);
		repeat (2) @(posedge I_CLK);
		chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
		rchk("unmapped", 8'h20, REG_ZERO);
		line.se0 <= 1'b1;
		repeat (124000) @(posedge I_CLK);
		rchk("status", ADDR_OTG_STATUS, st(line, 1'b0));
		repeat (1100) @(posedge I_CLK);
		rchk("status", ADDR_OTG_STATUS, st(line, 1'b1));
		line.j_state <= 1'b1;
		repeat (3) @(posedge I_CLK);
		rchk("status", ADDR_OTG_STATUS, st(line, 1'b0));
		conclude();
	end
endmodule : otg_status_token_tb
`default_nettype wire
